// File: core/swrom_master.sv
// Purpose: bus master for the identity command layer of a single-wire switch slave
// Assumes: line input synchronous to clk; pull-up outside; one clock
// Notes:   software chooses the operation; search direction bits come from a register
`timescale 1ns/1ns
`default_nettype none

module swrom_master
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // software register port
    input  wire swrom_pkg::swrom_req_t req,
    output var  logic [31:0]           rdData,
    // single-wire line
    input  wire logic                  lineIn,
    output var  logic                  lineOut,
    output var  logic                  lineOe
);

    typedef enum logic [3:0] {
        S_IDLE   = 4'h0,
        S_RSTLOW = 4'h1,
        S_PRES   = 4'h2,
        S_RTAIL  = 4'h3,
        S_CMD    = 4'h4,
        S_ROMTX  = 4'h5,
        S_ROMRX  = 4'h6,
        S_SRD    = 4'h7,
        S_SCMP   = 4'h8,
        S_SWR    = 4'h9,
        S_DONE   = 4'ha
    } swrom_state_t;

    // slot engine: write low, write high or read slot
    typedef enum logic [1:0] {
        SL_W0 = 2'h0,
        SL_W1 = 2'h1,
        SL_RD = 2'h2
    } swrom_slot_t;

    swrom_state_t      state_q, state_d;
    swrom_pkg::swrom_op_t op_q, op_d;
    logic [15:0]       cnt_q, cnt_d;
    logic [6:0]        bitIdx_q, bitIdx_d;
    logic [7:0]        cmd_q, cmd_d;
    logic [63:0]       id_q, id_d;
    logic [63:0]       dir_q, dir_d;
    logic [7:0]        info_q, info_d;
    logic              busy_q, busy_d;
    logic              pres_q, pres_d;
    logic              noDev_q, noDev_d;
    logic              trueBit_q, trueBit_d;
    logic              slotBusy_q, slotBusy_d;
    swrom_slot_t       slot_q, slot_d;
    logic              sampled_q, sampled_d;
    logic              lineOut_q, lineOut_d;
    logic              lineOe_q, lineOe_d;
    logic [31:0]       rdData_q, rdData_d;

    logic              slotStart;
    swrom_slot_t       slotKind;
    logic              slotDone;
    logic [15:0]       slotLow;

    assign rdData  = rdData_q;
    assign lineOut = lineOut_q;
    assign lineOe  = lineOe_q;

    always_comb
    begin
        case (slot_q)
            SL_W0:   slotLow = 16'(swrom_pkg::WRITE0_LOW_CYC);
            SL_W1:   slotLow = 16'(swrom_pkg::WRITE1_LOW_CYC);
            default: slotLow = 16'(swrom_pkg::READ_LOW_CYC);
        endcase
    end

    always_comb
    begin
        state_d    = state_q;
        op_d       = op_q;
        cnt_d      = cnt_q;
        bitIdx_d   = bitIdx_q;
        cmd_d      = cmd_q;
        id_d       = id_q;
        dir_d      = dir_q;
        info_d     = info_q;
        busy_d     = busy_q;
        pres_d     = pres_q;
        noDev_d    = noDev_q;
        trueBit_d  = trueBit_q;
        slotBusy_d = slotBusy_q;
        slot_d     = slot_q;
        sampled_d  = sampled_q;
        lineOut_d  = 1'b0;
        lineOe_d   = 1'b0;
        rdData_d   = 32'h0;
        slotStart  = 1'b0;
        slotKind   = SL_RD;
        slotDone   = 1'b0;

        // register reads, data the cycle after
        if (req.rd)
        begin
            case (req.addr)
                swrom_pkg::REG_CTRL:   rdData_d = {29'h0, op_q};
                swrom_pkg::REG_STATUS: rdData_d = {28'h0, info_q[swrom_pkg::INFO_CHANB_BIT],
                                                   noDev_q, pres_q, busy_q};
                swrom_pkg::REG_ID_LO:  rdData_d = id_q[31:0];
                swrom_pkg::REG_ID_HI:  rdData_d = id_q[63:32];
                swrom_pkg::REG_DIR_LO: rdData_d = dir_q[31:0];
                swrom_pkg::REG_DIR_HI: rdData_d = dir_q[63:32];
                swrom_pkg::REG_INFO:   rdData_d = {24'h0, info_q};
                default:               rdData_d = 32'h0;
            endcase
        end

        // register writes; ignored while a transaction runs
        if (req.wr && !busy_q)
        begin
            case (req.addr)
                swrom_pkg::REG_CTRL:
                begin
                    info_d = req.wdata[swrom_pkg::CTRL_INFO_LSB +: 8];
                    if (req.wdata[swrom_pkg::CTRL_START_BIT])
                    begin
                        op_d    = swrom_pkg::swrom_op_t'(req.wdata[swrom_pkg::CTRL_OP_LSB +: 3]);
                        busy_d  = 1'b1;
                        pres_d  = 1'b0;
                        noDev_d = 1'b0;
                        cnt_d   = 16'h0;
                        // line falls the cycle after start, so the pulse counts from here
                        lineOe_d = 1'b1;
                        state_d = S_RSTLOW;
                    end
                end
                swrom_pkg::REG_ID_LO:  id_d[31:0]   = req.wdata;
                swrom_pkg::REG_ID_HI:  id_d[63:32]  = req.wdata;
                swrom_pkg::REG_DIR_LO: dir_d[31:0]  = req.wdata;
                swrom_pkg::REG_DIR_HI: dir_d[63:32] = req.wdata;
                default: ;
            endcase
        end

        // slot engine: low phase, sample, recovery
        if (slotBusy_q)
        begin
            cnt_d = cnt_q + 16'h1;
            // the start cycle already drives low, so one cycle fewer here
            if (cnt_q + 16'h1 < slotLow)
            begin
                lineOe_d = 1'b1;
            end
            if (slot_q == SL_RD && cnt_q == 16'(swrom_pkg::READ_SAMPLE_CYC))
            begin
                sampled_d = lineIn;
            end
            if (cnt_q == 16'(swrom_pkg::SLOT_CYC + swrom_pkg::RECOVER_CYC))
            begin
                slotBusy_d = 1'b0;
                slotDone   = 1'b1;
                cnt_d      = 16'h0;
            end
        end

        case (state_q)
            S_IDLE: ;
            S_RSTLOW:
            begin
                lineOe_d = 1'b1;
                cnt_d    = cnt_q + 16'h1;
                if (cnt_q == 16'(swrom_pkg::RESET_LOW_CYC - 1))
                begin
                    cnt_d    = 16'h0;
                    lineOe_d = 1'b0;
                    state_d  = S_PRES;
                end
            end
            S_PRES:
            begin
                cnt_d = cnt_q + 16'h1;
                if (cnt_q == 16'(swrom_pkg::PRESENCE_CYC))
                begin
                    pres_d = ~lineIn;
                    state_d = S_RTAIL;
                end
            end
            S_RTAIL:
            begin
                cnt_d = cnt_q + 16'h1;
                if (cnt_q == 16'(swrom_pkg::RESET_TAIL_CYC))
                begin
                    cnt_d    = 16'h0;
                    bitIdx_d = 7'h0;
                    case (op_q)
                        swrom_pkg::OP_READ_ID: cmd_d = swrom_pkg::CMD_READ_ID;
                        swrom_pkg::OP_MATCH:   cmd_d = swrom_pkg::CMD_MATCH;
                        swrom_pkg::OP_SEARCH:  cmd_d = swrom_pkg::CMD_SEARCH;
                        swrom_pkg::OP_SKIP:    cmd_d = swrom_pkg::CMD_SKIP;
                        default:               cmd_d = swrom_pkg::CMD_COND_SRCH;
                    endcase
                    noDev_d = ~pres_q;
                    state_d = pres_q ? S_CMD : S_DONE;
                end
            end
            // command byte, least significant bit first
            S_CMD:
            begin
                if (!slotBusy_q && !slotDone)
                begin
                    slotStart = 1'b1;
                    slotKind  = cmd_q[bitIdx_q[2:0]] ? SL_W1 : SL_W0;
                end
                else if (slotDone)
                begin
                    bitIdx_d = bitIdx_q + 7'h1;
                    if (bitIdx_q == 7'h7)
                    begin
                        bitIdx_d = 7'h0;
                        case (op_q)
                            swrom_pkg::OP_READ_ID: state_d = S_ROMRX;
                            swrom_pkg::OP_MATCH:   state_d = S_ROMTX;
                            swrom_pkg::OP_SKIP:    state_d = S_DONE;
                            default:               state_d = S_SRD;
                        endcase
                    end
                end
            end
            S_ROMRX:
            begin
                if (!slotBusy_q && !slotDone)
                begin
                    slotStart = 1'b1;
                end
                else if (slotDone)
                begin
                    id_d[bitIdx_q[5:0]] = sampled_q;
                    bitIdx_d = bitIdx_q + 7'h1;
                    if (bitIdx_q == 7'h3f)
                    begin
                        state_d = S_DONE;
                    end
                end
            end
            S_ROMTX:
            begin
                if (!slotBusy_q && !slotDone)
                begin
                    slotStart = 1'b1;
                    slotKind  = id_q[bitIdx_q[5:0]] ? SL_W1 : SL_W0;
                end
                else if (slotDone)
                begin
                    bitIdx_d = bitIdx_q + 7'h1;
                    if (bitIdx_q == 7'h3f)
                    begin
                        state_d = S_DONE;
                    end
                end
            end
            S_SRD, S_SCMP:
            begin
                if (!slotBusy_q && !slotDone)
                begin
                    slotStart = 1'b1;
                end
                else if (slotDone)
                begin
                    if (state_q == S_SRD)
                    begin
                        trueBit_d = sampled_q;
                        state_d   = S_SCMP;
                    end
                    else if (trueBit_q && sampled_q)
                    begin
                        // nobody answered: no qualifying slave left
                        noDev_d = 1'b1;
                        state_d = S_DONE;
                    end
                    else
                    begin
                        // disagreeing bits: follow software direction
                        if (trueBit_q == sampled_q)
                        begin
                            id_d[bitIdx_q[5:0]] = dir_q[bitIdx_q[5:0]];
                        end
                        else
                        begin
                            id_d[bitIdx_q[5:0]] = trueBit_q;
                        end
                        state_d = S_SWR;
                    end
                end
            end
            // writing the bit prunes other slaves
            S_SWR:
            begin
                if (!slotBusy_q && !slotDone)
                begin
                    slotStart = 1'b1;
                    slotKind  = id_q[bitIdx_q[5:0]] ? SL_W1 : SL_W0;
                end
                else if (slotDone)
                begin
                    bitIdx_d = bitIdx_q + 7'h1;
                    state_d  = (bitIdx_q == 7'h3f) ? S_DONE : S_SRD;
                end
            end
            S_DONE:
            begin
                busy_d  = 1'b0;
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase

        if (slotStart)
        begin
            slotBusy_d = 1'b1;
            slot_d     = slotKind;
            cnt_d      = 16'h0;
            lineOe_d   = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q    <= S_IDLE;
            op_q       <= swrom_pkg::OP_READ_ID;
            cnt_q      <= 16'h0;
            bitIdx_q   <= 7'h0;
            cmd_q      <= 8'h0;
            id_q       <= 64'h0;
            dir_q      <= 64'h0;
            info_q     <= 8'h0;
            busy_q     <= 1'b0;
            pres_q     <= 1'b0;
            noDev_q    <= 1'b0;
            trueBit_q  <= 1'b0;
            slotBusy_q <= 1'b0;
            slot_q     <= SL_RD;
            sampled_q  <= 1'b0;
            lineOut_q  <= 1'b0;
            lineOe_q   <= 1'b0;
            rdData_q   <= 32'h0;
        end
        else
        begin
            state_q    <= state_d;
            op_q       <= op_d;
            cnt_q      <= cnt_d;
            bitIdx_q   <= bitIdx_d;
            cmd_q      <= cmd_d;
            id_q       <= id_d;
            dir_q      <= dir_d;
            info_q     <= info_d;
            busy_q     <= busy_d;
            pres_q     <= pres_d;
            noDev_q    <= noDev_d;
            trueBit_q  <= trueBit_d;
            slotBusy_q <= slotBusy_d;
            slot_q     <= slot_d;
            sampled_q  <= sampled_d;
            lineOut_q  <= lineOut_d;
            lineOe_q   <= lineOe_d;
            rdData_q   <= rdData_d;
        end
    end

endmodule

`default_nettype wire

// File: include/swrom_pkg.sv
// Purpose: shared constants and types for the single-wire identity command master
// Assumes: 20 MHz clock, single master on an open-drain line
// Notes:   slot times are the standard single-wire figures
package swrom_pkg;

    // clock rate in kHz
    localparam int unsigned CLK_KHZ        = 20000;

    // slot timing in microseconds, each turned into a cycle count
    localparam int unsigned RESET_LOW_US   = 480;
    localparam int unsigned PRESENCE_US    = 70;
    localparam int unsigned RESET_TAIL_US  = 410;
    localparam int unsigned SLOT_US        = 70;
    localparam int unsigned WRITE0_LOW_US  = 60;
    localparam int unsigned WRITE1_LOW_US  = 6;
    localparam int unsigned READ_LOW_US    = 6;
    localparam int unsigned READ_SAMPLE_US = 14;
    localparam int unsigned RECOVER_US     = 5;
    localparam int unsigned RESET_LOW_CYC   = (RESET_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned PRESENCE_CYC    = (PRESENCE_US * CLK_KHZ) / 1000;
    localparam int unsigned RESET_TAIL_CYC  = (RESET_TAIL_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned SLOT_CYC        = (SLOT_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned WRITE0_LOW_CYC  = (WRITE0_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned WRITE1_LOW_CYC  = (WRITE1_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned READ_LOW_CYC    = (READ_LOW_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned READ_SAMPLE_CYC = (READ_SAMPLE_US * CLK_KHZ) / 1000;
    localparam int unsigned RECOVER_CYC     = (RECOVER_US * CLK_KHZ + 999) / 1000;

    // identity command codes
    localparam logic [7:0] CMD_READ_ID   = 8'h33;
    localparam logic [7:0] CMD_MATCH     = 8'h55;
    localparam logic [7:0] CMD_SEARCH    = 8'hf0;
    localparam logic [7:0] CMD_SKIP      = 8'hcc;
    localparam logic [7:0] CMD_COND_SRCH = 8'hec;

    // software register offsets
    localparam logic [3:0] REG_CTRL    = 4'h0;
    localparam logic [3:0] REG_STATUS  = 4'h1;
    localparam logic [3:0] REG_ID_LO   = 4'h2;
    localparam logic [3:0] REG_ID_HI   = 4'h3;
    localparam logic [3:0] REG_DIR_LO  = 4'h4;
    localparam logic [3:0] REG_DIR_HI  = 4'h5;
    localparam logic [3:0] REG_INFO    = 4'h6;

    // control word fields
    localparam int unsigned CTRL_START_BIT = 31;
    localparam int unsigned CTRL_OP_LSB    = 0;
    localparam int unsigned CTRL_INFO_LSB  = 8;
    localparam int unsigned INFO_CHANB_BIT = 6;

    // status word fields
    localparam int unsigned ST_BUSY_BIT     = 0;
    localparam int unsigned ST_PRESENCE_BIT = 1;
    localparam int unsigned ST_NODEV_BIT    = 2;
    localparam int unsigned ST_CHANB_BIT    = 3;

    // software operations
    typedef enum logic [2:0] {
        OP_READ_ID = 3'h0,
        OP_MATCH   = 3'h1,
        OP_SEARCH  = 3'h2,
        OP_SKIP    = 3'h3,
        OP_COND    = 3'h4
    } swrom_op_t;

    // software register port
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } swrom_req_t;

    // open-drain line, two signals
    typedef struct packed {
        logic drvLow;
        logic oe;
    } swrom_line_t;

endpackage

// File: sim/swrom_master_properties.sv
// Purpose: port timing checks for the identity command master
// Assumes: one clock, counts in cycles of 50 ns
// Notes:   bound to every master instance
`timescale 1ns/1ns
`default_nettype none
module swrom_master_properties
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // software port
    input wire swrom_pkg::swrom_req_t req,
    input wire logic [31:0]           rdData,
    // line
    input wire logic                  lineIn,
    input wire logic                  lineOut,
    input wire logic                  lineOe
);
    logic [15:0] runCnt_q, runCnt_d, idleCnt_q, idleCnt_d, lastRun_q, lastRun_d;
    logic        fresh_q, fresh_d;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // idle count saturates so a long pause never wraps back into the slot range
    always_comb
    begin
        runCnt_d  = lineOe ? runCnt_q + 16'h1 : 16'h0;
        idleCnt_d = lineOe ? 16'h0 : idleCnt_q + {15'h0, ~&idleCnt_q};
        lastRun_d = (!lineOe && runCnt_q != 16'h0) ? runCnt_q : lastRun_q;
        fresh_d   = (idleCnt_q > 16'd8300) || (fresh_q && (lineOe || runCnt_q == 16'h0));
    end
    always_ff @(posedge clk)
    begin
        runCnt_q  <= sys_rst ? 16'h0 : runCnt_d;
        idleCnt_q <= sys_rst ? 16'h0 : idleCnt_d;
        lastRun_q <= sys_rst ? 16'h0 : lastRun_d;
        fresh_q   <= sys_rst || fresh_d;
    end
    sequence pulseEnd;
        $fell(lineOe);
    endsequence
    sequence firstPulseEnd;
        $fell(lineOe) && fresh_q;
    endsequence
    out_low_a: assert property (lineOut == 1'b0)
        else $error("line data output not low");
    rd_quiet_a: assert property (!req.rd |=> rdData == 32'h0)
        else $error("read data outside the read answer cycle");
    unmapped_zero_a: assert property (req.rd && req.addr > 4'h6 |=> rdData == 32'h0)
        else $error("unmapped read not zero");
    pulse_width_a: assert property (pulseEnd |-> runCnt_q inside {16'd9600, 16'd1200, 16'd120})
        else $error("low pulse of wrong length");
    first_reset_a: assert property (firstPulseEnd |-> runCnt_q == 16'd9600)
        else $error("transfer not opened by reset pulse");
    reset_tail_a: assert property ($rose(lineOe) && lastRun_q == 16'd9600 |-> idleCnt_q >= 16'd8000)
        else $error("command slot inside presence window");
    slot_period_a: assert property ($rose(lineOe) && lastRun_q inside {16'd1200, 16'd120}
        |-> lastRun_q + idleCnt_q >= 16'd1500)
        else $error("slot shorter than its period");
    recover_gap_a: assert property (pulseEnd |-> !lineOe [*8])
        else $error("no recovery after low pulse");
endmodule
bind swrom_master swrom_master_properties swrom_master_properties_inst
(
    .clk(clk), .sys_rst(sys_rst), .req(req), .rdData(rdData),
    .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe)
);
`default_nettype wire

// File: sim/swrom_master_tb.sv
// Purpose: self-checking bench for the identity command master
// Assumes: slave model on an open-drain line with pull-up
// Notes:   a full search is too long for the run, so only short walks
`timescale 1ns/1ns
`default_nettype none
module swrom_master_tb;
    logic                  clk     = 1'b0;
    logic                  sys_rst = 1'b1;
    swrom_pkg::swrom_req_t req     = '0;
    logic                  cfgWr   = 1'b0;
    logic [4:0]            cfgBits = 5'h1f;
    logic [31:0]           rdData;
    logic                  lineOut, lineOe, pullLow;
    logic [7:0]            cmdSeen;
    int                    errors   = 0;
    int                    compares = 0;
    wire logic busLine = !(lineOe || pullLow);
    always #25 clk = !clk;
    swrom_master swrom_master_inst (.clk(clk), .sys_rst(sys_rst), .req(req), .rdData(rdData),
        .lineIn(busLine), .lineOut(lineOut), .lineOe(lineOe));
    swrom_slave_model swrom_slave_model_inst (.clk(clk), .busLine(busLine), .pullLow(pullLow),
        .cfgWr(cfgWr), .cfgBits(cfgBits), .ffAB(2'h3), .pinAB(2'h0), .cmdSeen(cmdSeen));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdData;
    endtask
    task automatic start(input swrom_pkg::swrom_op_t op, input logic [7:0] info);
        wr_reg(swrom_pkg::REG_CTRL, {1'b1, 15'h0, info, 5'h0, op});
    endtask
    task automatic wait_idle();
        logic [31:0] st;
        for (int n = 0; n < 40000; n++)
        begin
            rd_reg(swrom_pkg::REG_STATUS, st);
            if (st[swrom_pkg::ST_BUSY_BIT] === 1'b0) return;
        end
        errors++;
        $display("BAD busy expected 0 seen 1");
        wrap_up();
    endtask
    task automatic scn_skip();
        logic [31:0] d;
        rd_reg(swrom_pkg::REG_STATUS, d);
        check("status after reset", 32'h0, d);
        wr_reg(swrom_pkg::REG_ID_LO, 32'h5a5a0ff0);
        wr_reg(swrom_pkg::REG_DIR_HI, 32'h0000a5c3);
        rd_reg(4'hf, d);
        check("unmapped read", 32'h0, d);
        start(swrom_pkg::OP_SKIP, 8'h00);
        rd_reg(swrom_pkg::REG_STATUS, d);
        check("busy", 32'h1, {31'h0, d[swrom_pkg::ST_BUSY_BIT]});
        // a write while busy must be dropped
        wr_reg(swrom_pkg::REG_ID_LO, 32'h0);
        wait_idle();
        rd_reg(swrom_pkg::REG_ID_LO, d);
        check("id low kept", 32'h5a5a0ff0, d);
        rd_reg(swrom_pkg::REG_DIR_HI, d);
        check("direction high", 32'h0000a5c3, d);
        check("skip command", {24'h0, swrom_pkg::CMD_SKIP}, {24'h0, cmdSeen});
        rd_reg(swrom_pkg::REG_STATUS, d);
        check("presence", 32'h1, {31'h0, d[swrom_pkg::ST_PRESENCE_BIT]});
    endtask
    task automatic scn_cond();
        logic [31:0] d;
        @(posedge clk);
        cfgBits <= 5'h19;
        cfgWr   <= 1'b1;
        @(posedge clk);
        cfgWr <= 1'b0;
        start(swrom_pkg::OP_COND, 8'h40);
        wait_idle();
        check("cond command", {24'h0, swrom_pkg::CMD_COND_SRCH}, {24'h0, cmdSeen});
        rd_reg(swrom_pkg::REG_STATUS, d);
        check("nobody found", 32'h1, {31'h0, d[swrom_pkg::ST_NODEV_BIT]});
        check("channel b", 32'h1, {31'h0, d[swrom_pkg::ST_CHANB_BIT]});
        rd_reg(swrom_pkg::REG_INFO, d);
        check("info byte", 32'h40, d);
        rd_reg(swrom_pkg::REG_CTRL, d);
        check("operation", 32'h4, d);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        scn_skip();
        scn_cond();
        wrap_up();
    end
endmodule
`default_nettype wire

// File: sim/swrom_slave_model.sv
// Purpose: behavioural switch slave on the single-wire line
// Assumes: samples the wired line on each rising clk edge
// Notes:   no memory or channel functions, identity level only
`timescale 1ns/1ns
`default_nettype none
module swrom_slave_model
#(
    parameter logic [63:0] ID_CODE = 64'h0123456789abcdef, // arbitrary value
    parameter bit          HAS_B   = 1'b0
)
(
    // clock and line
    input  wire logic       clk,
    input  wire logic       busLine,
    output var  logic       pullLow,
    // condition write and channel state
    input  wire logic       cfgWr,
    input  wire logic [4:0] cfgBits,
    input  wire logic [1:0] ffAB,
    input  wire logic [1:0] pinAB,
    // last command byte taken
    output var  logic [7:0] cmdSeen
);
    // condition bits ones at power up
    logic [4:0] cond     = 5'h1f;
    logic [1:0] actLatch = 2'h0;
    logic [1:0] pinPrev  = 2'h0;
    // clearing needs the channel access command, which is not modelled
    always @(posedge clk)
    begin
        if (cfgWr) cond <= cfgBits;
        actLatch <= actLatch | (pinAB ^ pinPrev);
        pinPrev  <= pinAB;
    end
    function automatic logic qualifies();
        logic [1:0] src;
        case (cond[2:1])
            2'b01:   src = actLatch;
            2'b10:   src = ffAB;
            2'b11:   src = pinAB;
            default: return !cond[0];
        endcase
        src[1] = src[1] & HAS_B;
        case (cond[4:3])
            2'b00:   return !cond[0];
            2'b01:   return src[0] == cond[0];
            2'b10:   return src[1] == cond[0];
            default: return (|src) == cond[0];
        endcase
    endfunction
    // one slot: a zero is held well past the master sample point
    task automatic slot(input logic tx, output logic rx);
        while (busLine !== 1'b0) @(posedge clk);
        pullLow <= !tx;
        repeat (600) @(posedge clk);
        rx = busLine;
        pullLow <= 1'b0;
        while (busLine !== 1'b1) @(posedge clk);
    endtask
    initial
    begin
        int n;
        logic b;
        logic live;
        logic [7:0] cmd;
        pullLow = 1'b0;
        cmdSeen = 8'h0;
        forever
        begin
            n = 0;
            @(posedge clk);
            while (busLine === 1'b0)
            begin
                n++;
                @(posedge clk);
            end
            if (n >= 9000)
            begin
                repeat (600) @(posedge clk);
                pullLow <= 1'b1;
                repeat (2400) @(posedge clk);
                pullLow <= 1'b0;
                // own presence must not be taken for the first command slot
                while (busLine !== 1'b1) @(posedge clk);
                for (int i = 0; i < 8; i++)
                begin
                    slot(1'b1, b);
                    cmd[i] = b;
                end
                cmdSeen <= cmd;
                // condition sampled as the byte completes
                live = cmd inside {swrom_pkg::CMD_READ_ID, swrom_pkg::CMD_MATCH, swrom_pkg::CMD_SEARCH}
                    || (cmd == swrom_pkg::CMD_COND_SRCH && qualifies());
                // identity bits, losers idle until reset
                for (int i = 0; i < 64 && live; i++)
                begin
                    if (cmd != swrom_pkg::CMD_MATCH) slot(ID_CODE[i], b);
                    if (cmd == swrom_pkg::CMD_READ_ID) continue;
                    if (cmd != swrom_pkg::CMD_MATCH) slot(!ID_CODE[i], b);
                    slot(1'b1, b);
                    live = b === ID_CODE[i];
                end
            end
        end
    end
endmodule
`default_nettype wire
